// [src/rps_pkg.sv]
`default_nettype none
package rps_pkg;

  // ----------------------------------------
  // sequence variants
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    RPS_SEQ_POWER_ON,
    RPS_SEQ_DESTRUCTIVE,
    RPS_SEQ_EXTERNAL,
    RPS_SEQ_FUNC_LONG,
    RPS_SEQ_FUNC_SHORT
  } rps_variant_type;

  localparam int RPS_NUM_VARIANTS = 5;
  localparam int RPS_NUM_SOURCES = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int RPS_CLK_MHZ = 100;
  localparam int RPS_BOOT_TYP_US = 200;
  localparam int RPS_BOOT_MAX_US = 320;
  localparam int RPS_BOOT_TYP_CYC = RPS_BOOT_TYP_US * RPS_CLK_MHZ;
  localparam int RPS_BOOT_MAX_CYC = RPS_BOOT_MAX_US * RPS_CLK_MHZ;
  localparam int RPS_PHASE1_CYC = 16;
  localparam int RPS_PHASE2_CYC = 16;
  localparam int RPS_FINAL_RESET_PHASE_CYC = 16;
  localparam int RPS_SHORT_CYC = 8;
  localparam int RPS_CNT_W = 16;

endpackage : rps_pkg
`default_nettype wire

// [src/rps_reset_seq.sv]
// Summary of operation
// R01: reset pin is shared; device and external generator may both pull low.
// R02: device only drives low; high comes from external pull-up only.
// R03: device releases its low drive at the end of its final phase.
// R04: pin held low externally after final phase extends the sequence.
// R05: functional reset drives pin only if source pin-drive enable is set.
// R06: boot firmware ends entering main run mode; first fetch strobes then.
// R07: five sequence variants; four run phases 1 to 3, the short functional one runs phase 3 only.
// R08: boot firmware takes 200 us typical, 320 us worst case.
// R09: boot latency is reset sequence plus boot firmware time.
// R10: sampled pin level is synchronised before use.
`timescale 1ns/1ps
`default_nettype none
module rps_reset_seq
  import rps_pkg::*;
#(
  parameter int BOOT_TYP_CYC = rps_pkg::RPS_BOOT_TYP_CYC,
  parameter int BOOT_MAX_CYC = rps_pkg::RPS_BOOT_MAX_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // reset requests
  input wire logic destr_req,
  input wire logic func_req,
  input wire logic [rps_pkg::RPS_NUM_SOURCES-1:0] func_src,
  input wire logic func_short,
  input wire logic [rps_pkg::RPS_NUM_SOURCES-1:0]
    functional_reset_pin_drive_enable,
  // boot header position
  input wire logic header_last,
  // reset pin, active low, open drain
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  // status
  output logic in_reset,
  output logic boot_assist_firmware,
  output logic main_run_mode,
  output logic first_fetch,
  output rps_pkg::rps_variant_type variant
);
  import rps_pkg::*;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic pin_meta_ff, pin_sync_ff, nxt_pin_meta, nxt_pin_sync;
  always_comb
  begin
    nxt_pin_meta = reset_pin_n_in;
    nxt_pin_sync = pin_meta_ff; // see R10
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end
    else
    begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ST_PH1, ST_PH2, ST_PH3, ST_WAIT_PIN, ST_BOOT, ST_RUN
  } rps_state_type;

  rps_state_type state_ff, nxt_state;
  rps_variant_type var_ff, nxt_var;
  logic [RPS_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic drive_ff, nxt_drive;
  logic fetch_ff, nxt_fetch;
  logic [RPS_CNT_W-1:0] boot_len;

  function automatic logic [RPS_CNT_W-1:0] to_cnt(input int v);
    to_cnt = RPS_CNT_W'(v - 1);
  endfunction : to_cnt

  assign boot_len = header_last ? to_cnt(BOOT_MAX_CYC)
                                : to_cnt(BOOT_TYP_CYC); // see R08

  always_comb
  begin
    nxt_state = state_ff;
    nxt_var = var_ff;
    nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    nxt_drive = drive_ff;
    nxt_fetch = 1'b0;
    case (state_ff)
      ST_PH1:
        if (cnt_ff == '0)
        begin
          nxt_state = ST_PH2;
          nxt_cnt = to_cnt(RPS_PHASE2_CYC);
        end
      ST_PH2:
        if (cnt_ff == '0)
        begin
          nxt_state = ST_PH3;
          nxt_cnt = to_cnt(RPS_FINAL_RESET_PHASE_CYC);
        end
      ST_PH3:
        if (cnt_ff == '0)
        begin
          nxt_state = ST_WAIT_PIN;
          nxt_drive = 1'b0; // see R03
        end
      ST_WAIT_PIN:
        // waits two cycles past release for pin sync to settle
        if (pin_sync_ff && !drive_ff && !reset_pin_n_oe) // see R04
        begin
          nxt_state = ST_BOOT;
          nxt_cnt = boot_len; // see R09
        end
      ST_BOOT:
        if (cnt_ff == '0)
        begin
          nxt_state = ST_RUN;
          nxt_fetch = 1'b1; // see R06
        end
      ST_RUN:
      begin
        if (destr_req)
        begin
          nxt_state = ST_PH1; // see R07
          nxt_var = RPS_SEQ_DESTRUCTIVE;
          nxt_cnt = to_cnt(RPS_PHASE1_CYC);
          nxt_drive = 1'b1;
        end
        else if (!pin_sync_ff)
        begin
          nxt_state = ST_PH1;
          nxt_var = RPS_SEQ_EXTERNAL;
          nxt_cnt = to_cnt(RPS_PHASE1_CYC);
          nxt_drive = 1'b1;
        end
        else if (func_req)
        begin
          nxt_var = func_short ? RPS_SEQ_FUNC_SHORT : RPS_SEQ_FUNC_LONG;
          nxt_state = func_short ? ST_PH3 : ST_PH1;
          nxt_cnt = func_short ? to_cnt(RPS_SHORT_CYC)
                               : to_cnt(RPS_PHASE1_CYC);
          nxt_drive = |(func_src & functional_reset_pin_drive_enable); // see R05
        end
      end
      default:
        nxt_state = ST_PH1;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_PH1;
      var_ff <= RPS_SEQ_POWER_ON;
      cnt_ff <= RPS_CNT_W'(RPS_PHASE1_CYC - 1);
      drive_ff <= 1'b1;
      fetch_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      var_ff <= nxt_var;
      cnt_ff <= nxt_cnt;
      drive_ff <= nxt_drive;
      fetch_ff <= nxt_fetch;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic oe_ff, run_ff, boot_ff, inrst_ff;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      oe_ff <= 1'b1;
      run_ff <= 1'b0;
      boot_ff <= 1'b0;
      inrst_ff <= 1'b1;
    end
    else
    begin
      oe_ff <= nxt_drive; // see R01
      run_ff <= (nxt_state == ST_RUN);
      boot_ff <= (nxt_state == ST_BOOT);
      inrst_ff <= (nxt_state != ST_RUN) && (nxt_state != ST_BOOT);
    end
  end

  assign reset_pin_n_oe = oe_ff;
  assign reset_pin_n_out = 1'b0; // see R02
  assign main_run_mode = run_ff;
  assign boot_assist_firmware = boot_ff;
  assign in_reset = inrst_ff;
  assign first_fetch = fetch_ff;
  assign variant = var_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_boot_done;
    state_ff == ST_BOOT && cnt_ff == '0;
  endsequence

  chk_never_high: assert property ( // see R02
    reset_pin_n_oe |-> !reset_pin_n_out)
    else $error("reset pin driven high");
  chk_hold_ext: assert property ( // see R04
    (state_ff == ST_WAIT_PIN && !pin_sync_ff) |=> state_ff == ST_WAIT_PIN)
    else $error("sequence left wait while pin low");
  chk_release_ph3: assert property ( // see R03
    (state_ff == ST_PH3 && cnt_ff == '0) |=> !reset_pin_n_oe)
    else $error("pin not released after final phase");
  chk_fetch_run: assert property ( // see R06
    s_boot_done |=> first_fetch && main_run_mode)
    else $error("no fetch on run entry");
  chk_fetch_pulse: assert property ( // see R06
    first_fetch |=> !first_fetch)
    else $error("fetch not single pulse");
  chk_func_gate: assert property ( // see R05
    (state_ff == ST_RUN && !destr_req && pin_sync_ff && func_req &&
     !(|(func_src & functional_reset_pin_drive_enable)))
    |=> !reset_pin_n_oe)
    else $error("functional reset drove pin while disabled");
  chk_boot_len: assert property ( // see R08
    (state_ff == ST_WAIT_PIN && nxt_state == ST_BOOT)
    |=> cnt_ff == ($past(header_last)
      ? RPS_CNT_W'(BOOT_MAX_CYC - 1)
      : RPS_CNT_W'(BOOT_TYP_CYC - 1)))
    else $error("boot length wrong");
  chk_boot_after: assert property ( // see R09
    $rose(boot_assist_firmware) |-> $past(in_reset))
    else $error("boot firmware not after reset sequence");
  chk_sync_lag: assert property ( // see R10
    ##2 pin_sync_ff == $past(reset_pin_n_in, 2))
    else $error("pin sync depth wrong");
  chk_destr_var: assert property ( // see R07
    (state_ff == ST_RUN && destr_req)
    |=> variant == RPS_SEQ_DESTRUCTIVE && reset_pin_n_oe)
    else $error("destructive variant not started");

endmodule : rps_reset_seq
`default_nettype wire

// [dv/rps_pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module rps_pin_partner
(
  // device side
  input wire logic pin_n_oe,
  input wire logic pin_n_out,
  // generator side
  input wire logic gen_hold,
  output logic pin_n
);
  // ------------------------------
  // wired pin
  // ------------------------------
  // either party pulls low, pull-up wins otherwise
  assign pin_n = !((pin_n_oe && !pin_n_out) || gen_hold);
endmodule : rps_pin_partner
`default_nettype wire

// [dv/reset_pin_sequencing_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module reset_pin_sequencing_bench;
  import rps_pkg::*;
  localparam int BT = 20;
  localparam int BM = 32;
  localparam int LONG_OE = RPS_PHASE1_CYC + RPS_PHASE2_CYC + RPS_FINAL_RESET_PHASE_CYC;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic destr_req = 1'b0;
  logic func_req = 1'b0;
  logic [3:0] func_src = 4'h0;
  logic func_short = 1'b0;
  logic [3:0] drv_en = 4'h0;
  logic header_last = 1'b0;
  logic gen_hold = 1'b0;
  logic pin_n, oe, pout, in_reset, boot, run, fetch;
  rps_variant_type variant;
  int err_total = 0;
  int checked = 0;
  int n_oe, n_boot, n_ff, n_hi;
  rps_reset_seq #(.BOOT_TYP_CYC(BT), .BOOT_MAX_CYC(BM)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .destr_req(destr_req),
    .func_req(func_req), .func_src(func_src), .func_short(func_short),
    .functional_reset_pin_drive_enable(drv_en),
    .header_last(header_last), .reset_pin_n_in(pin_n),
    .reset_pin_n_out(pout), .reset_pin_n_oe(oe), .in_reset(in_reset),
    .boot_assist_firmware(boot), .main_run_mode(run),
    .first_fetch(fetch), .variant(variant));
  rps_pin_partner gen (.pin_n_oe(oe), .pin_n_out(pout),
    .gen_hold(gen_hold), .pin_n(pin_n));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // count until run mode is reached
  task automatic measure();
    n_oe = 0;
    n_boot = 0;
    n_ff = 0;
    n_hi = 0;
    repeat (3000)
    begin
      @(posedge clk_sys);
      destr_req <= 1'b0;
      func_req <= 1'b0;
      #1;
      n_oe += int'(oe);
      n_boot += int'(boot);
      n_ff += int'(fetch);
      n_hi += int'(pout);
      if (run === 1'b1)
        break;
    end
    chk("run", run, 1);
    chk("in_reset", in_reset, 0);
    chk("fetch", n_ff, 1);
    chk("drive_high", n_hi, 0);
    @(posedge clk_sys);
    #1;
    chk("fetch_end", fetch, 0);
  endtask : measure
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_power();
    measure();
    chk("variant", variant, RPS_SEQ_POWER_ON);
    chk("boot", n_boot, BT);
    $display("done power on");
  endtask : t_power
  task automatic t_destr();
    @(posedge clk_sys);
    header_last <= 1'b1;
    destr_req <= 1'b1;
    measure();
    chk("variant", variant, RPS_SEQ_DESTRUCTIVE);
    chk("oe_len", n_oe, LONG_OE);
    chk("boot", n_boot, BM);
    @(posedge clk_sys);
    header_last <= 1'b0;
    $display("done destructive");
  endtask : t_destr
  task automatic t_func(logic sh, logic [3:0] src, logic [3:0] en);
    int exp_oe;
    @(posedge clk_sys);
    func_short <= sh;
    func_src <= src;
    drv_en <= en;
    func_req <= 1'b1;
    measure();
    chk("variant", variant, sh ? RPS_SEQ_FUNC_SHORT : RPS_SEQ_FUNC_LONG);
    chk("drive", n_oe != 0, |(src & en));
    exp_oe = ((src & en) == 4'h0) ? 0 : (sh ? RPS_SHORT_CYC : LONG_OE);
    chk("oe_len", n_oe, exp_oe);
    chk("boot", n_boot, BT);
    @(posedge clk_sys);
    func_short <= 1'b0;
    $display("done functional");
  endtask : t_func
  task automatic t_ext();
    @(posedge clk_sys);
    gen_hold <= 1'b1;
    repeat (100) @(posedge clk_sys);
    #1;
    chk("held", in_reset, 1);
    chk("held_boot", boot, 0);
    @(posedge clk_sys);
    gen_hold <= 1'b0;
    measure();
    chk("variant", variant, RPS_SEQ_EXTERNAL);
    chk("boot", n_boot, BT);
    $display("done external");
  endtask : t_ext
  task automatic t_rst();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rst_oe", oe, 1);
    chk("rst_in_reset", in_reset, 1);
    chk("rst_run", run, 0);
    chk("rst_variant", variant, RPS_SEQ_POWER_ON);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    measure();
    chk("variant", variant, RPS_SEQ_POWER_ON);
    chk("boot", n_boot, BT);
    $display("done mid reset");
  endtask : t_rst
  // ------------------------------
  // main and watchdog
  // ------------------------------
  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_power();
    t_destr();
    t_func(1'b0, 4'h1, 4'hE);
    t_func(1'b1, 4'h4, 4'h4);
    t_ext();
    t_rst();
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    conclude();
  end
endmodule : reset_pin_sequencing_bench
`default_nettype wire
